/* design/slave_port.sv */
`timescale 1ns/100ps
module slave_port #(
  parameter int STACK_DEPTH = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // host bus pins
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_reg_select,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  // test pins
  input wire logic i_test_pin_a,
  input wire logic i_event_pin_b,
  // port 2 pins
  input wire logic [7:0] i_port2,
  output logic [7:0] o_port2,
  // core operation port
  input wire slave_port_pkg::op_type i_op,
  input wire logic [1:0] i_op_arg,
  input wire logic [7:0] i_acc,
  output logic o_op_ready,
  output logic o_branch,
  output logic [7:0] o_counter,
  // host_in data toward the core
  output logic [7:0] o_in_data,
  output logic o_in_valid,
  input wire logic i_in_ready,
  // interrupt sequencing with the core
  input wire logic i_instr_end,
  input wire logic [11:0] i_pc,
  input wire logic [3:0] i_psw_hi,
  output logic o_vector_call,
  output logic [11:0] o_vector,
  output logic o_restore,
  output logic [11:0] o_ret_pc,
  output logic [3:0] o_ret_psw,
  output logic [7:0] o_status
);
  import slave_port_pkg::*;

  localparam int SPW = $clog2(STACK_DEPTH);

  generate
    if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("stack depth must be a power of two, at least 2");
    end
  endgenerate

  // two-flop synchronisers; first stage read by second only
  logic [14:0] pin_s1_reg;
  logic [14:0] pin_s2_reg;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pin_s1_reg <= 15'h7fff;
      pin_s2_reg <= 15'h7fff;
    end
    else
    begin
      pin_s1_reg <= {i_port2[P2_DMA_ACK], i_test_pin_a, i_event_pin_b,
                     i_reg_select, i_cs_n, i_rd_n, i_wr_n, i_data};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  // synchronised views
  logic [7:0] data_s;
  logic wr_n_s, rd_n_s, cs_n_s, a0_s, pin_b_s, pin_a_s, dack_n_s;
  assign {dack_n_s, pin_a_s, pin_b_s, a0_s, cs_n_s, rd_n_s, wr_n_s,
          data_s} = pin_s2_reg;

  // mode, enable and flag state
  cnt_mode_type cnt_mode_reg;  // counter source
  logic flags_en_reg;  // host irq pins allocated
  logic dma_en_reg;  // dma pins allocated
  logic in_irq_en_reg, tmr_irq_en_reg, in_service_reg;
  logic in_req_reg, tmr_req_reg, tflag_reg;
  logic out_full_reg, in_full_reg, user_flag_reg, cmd_flag_reg;
  logic [3:0] user_reg;
  logic [7:0] in_buf_reg, out_buf_reg, p2_latch_reg;

  // host strobes: dma ack also selects for writes
  logic wr_sel, rd_act, wr_act_reg, rd_act_reg, a0_l_reg;
  // ack level is gone by the time the write is taken, so keep it
  logic dack_l_reg;
  logic [7:0] data_l_reg;
  assign wr_sel = !wr_n_s && (!cs_n_s || (dma_en_reg && !dack_n_s));
  assign rd_act = !rd_n_s && !cs_n_s;
  // write taken at strobe release, data held from strobe
  logic host_wr, host_rd_data;
  assign host_wr = wr_act_reg && !wr_sel;
  assign host_rd_data = rd_act_reg && !rd_act && !a0_l_reg;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_act_reg <= 1'b0;
      rd_act_reg <= 1'b0;
      a0_l_reg <= 1'b0;
      dack_l_reg <= 1'b0;
      data_l_reg <= 8'h00;
    end
    else
    begin
      wr_act_reg <= wr_sel;
      rd_act_reg <= rd_act;
      if (wr_sel || rd_act)
      begin
        a0_l_reg <= a0_s;
        dack_l_reg <= !dack_n_s;
        data_l_reg <= data_s;
      end
    end
  end

  // data bus output from flops; status or out buffer
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end
    else
    begin
      o_data_oe <= rd_act;
      o_data <= a0_s ? o_status : out_buf_reg;
    end
  end

  // two-entry buffer of host_in bytes toward the core
  logic [7:0] fifo_b_reg;
  logic fifo_b_v_reg;
  logic take_in;
  // o_op_ready is a flop that mirrors a free second slot
  assign take_in = (i_op == OP_READ_IN) && o_op_ready;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_in_data <= 8'h00;
      o_in_valid <= 1'b0;
      fifo_b_reg <= 8'h00;
      fifo_b_v_reg <= 1'b0;
      o_op_ready <= 1'b1;
    end
    else
    begin
      // head drains, second slot shifts up
      if (!o_in_valid || i_in_ready)
      begin
        o_in_valid <= fifo_b_v_reg || take_in;
        o_in_data <= fifo_b_v_reg ? fifo_b_reg : in_buf_reg;
        fifo_b_v_reg <= fifo_b_v_reg && take_in;
        o_op_ready <= 1'b1;
        if (fifo_b_v_reg && take_in)
          fifo_b_reg <= in_buf_reg;
      end
      else if (take_in)
      begin
        fifo_b_v_reg <= 1'b1;
        o_op_ready <= 1'b0;  // stalls reads of host_in
        fifo_b_reg <= in_buf_reg;
      end
    end
  end

  // host data buffers and status flags; sets win over clears
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      {user_reg, cmd_flag_reg, user_flag_reg, in_full_reg, out_full_reg} <=
        STATUS_RST;
      in_buf_reg <= 8'h00;
      out_buf_reg <= 8'h00;
    end
    else
    begin
      if (host_wr)
      begin
        in_buf_reg <= data_l_reg;
        cmd_flag_reg <= a0_l_reg;
      end
      else if (i_op == OP_CLR_CMD_FLAG)
        cmd_flag_reg <= 1'b0;
      else if (i_op == OP_CPL_CMD_FLAG)
        cmd_flag_reg <= !cmd_flag_reg;
      if (i_op == OP_CLR_USER_FLAG)
        user_flag_reg <= 1'b0;
      else if (i_op == OP_CPL_USER_FLAG)
        user_flag_reg <= !user_flag_reg;
      if (i_op == OP_LOAD_STATUS)
        user_reg <= i_acc[7:4];
      if (host_wr)
        in_full_reg <= 1'b1;
      else if (take_in)
        in_full_reg <= 1'b0;
      if (i_op == OP_WRITE_OUT)
      begin
        out_buf_reg <= i_acc;
        out_full_reg <= 1'b1;
      end
      else if (host_rd_data)
        out_full_reg <= 1'b0;
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_status <= STATUS_RST;
    else
      o_status <= {user_reg, cmd_flag_reg, user_flag_reg, in_full_reg,
                   out_full_reg};
  end

  // machine cycle divider and timer prescaler
  logic [$clog2(MC_CLKS)-1:0] mc_cnt_reg;
  logic [4:0] pre_cnt_reg;
  logic mc_tick;
  assign mc_tick = (mc_cnt_reg == ($clog2(MC_CLKS))'(MC_CLKS - 1));
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      mc_cnt_reg <= '0;
      pre_cnt_reg <= 5'h00;
    end
    else
    begin
      mc_cnt_reg <= mc_tick ? '0 : mc_cnt_reg + 1'b1;
      if (i_op == OP_START_TIMER)
        pre_cnt_reg <= 5'h00;
      else if (mc_tick)
        pre_cnt_reg <= pre_cnt_reg + 5'h01;
    end
  end

  // counter mode; event pin stays testable in every mode
  logic seen_high_reg, cnt_inc;
  assign cnt_inc = mc_tick && (
    (cnt_mode_reg == CNT_TIMER && pre_cnt_reg == 5'(PRESCALE - 1)) ||
    (cnt_mode_reg == CNT_EVENT && seen_high_reg && !pin_b_s));
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_mode_reg <= CNT_STOP;
      seen_high_reg <= 1'b0;
    end
    else
    begin
      unique case (i_op)
        OP_BEGIN_EVENT_COUNT: cnt_mode_reg <= CNT_EVENT;
        OP_START_TIMER: cnt_mode_reg <= CNT_TIMER;
        OP_STOP: cnt_mode_reg <= CNT_STOP;
        default: ;
      endcase
      // one sample per machine cycle; a low after a high counts
      if (cnt_mode_reg != CNT_EVENT)
        seen_high_reg <= 1'b0;
      else if (mc_tick)
        seen_high_reg <= pin_b_s;
    end
  end

  // counter is never cleared by reset, only loaded by software
  logic [7:0] count_q;
  always_ff @(posedge i_clk)
  begin
    if (i_op == OP_LOAD_COUNTER)
      count_q <= i_acc;
    else if (cnt_inc)
      count_q <= count_q + 8'h01;
  end
  assign o_counter = count_q;

  // conditional branch sampling
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_branch <= 1'b0;
    else if (i_op == OP_JUMP_TEST)
      o_branch <= (i_op_arg[0] ? pin_b_s : pin_a_s) == i_op_arg[1];
    else if (i_op == OP_JUMP_TFLAG)
      o_branch <= tflag_reg;
  end

  // interrupt requests, enables and acceptance
  logic accept, pick_in, wrap, return_restore_wait_reg;
  assign wrap = cnt_inc && (count_q == 8'hff);
  assign accept = i_instr_end && !in_service_reg &&
                  ((in_req_reg && in_irq_en_reg) ||
                   (tmr_req_reg && tmr_irq_en_reg));
  assign pick_in = in_req_reg && in_irq_en_reg;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      in_irq_en_reg <= 1'b0;
      tmr_irq_en_reg <= 1'b0;
      in_req_reg <= 1'b0;
      tmr_req_reg <= 1'b0;
      tflag_reg <= 1'b0;
      in_service_reg <= 1'b0;
      return_restore_wait_reg <= 1'b0;
    end
    else
    begin
      if (i_op == OP_EN_IN_IRQ)
        in_irq_en_reg <= 1'b1;
      else if (i_op == OP_DIS_IN_IRQ)
        in_irq_en_reg <= 1'b0;
      if (i_op == OP_EN_TMR_IRQ)
        tmr_irq_en_reg <= 1'b1;
      else if (i_op == OP_DIS_TMR_IRQ)
        tmr_irq_en_reg <= 1'b0;
      // request set wins; disabling never clears it
      if (host_wr)
        in_req_reg <= 1'b1;
      else if (accept && pick_in)
        in_req_reg <= 1'b0;
      if (wrap)
        tmr_req_reg <= 1'b1;
      else if (accept && !pick_in)
        tmr_req_reg <= 1'b0;
      if (wrap)
        tflag_reg <= 1'b1;
      else if (i_op == OP_JUMP_TFLAG)
        tflag_reg <= 1'b0;
      // acceptance reopens at the first machine cycle tick after return_restore
      if (i_op == OP_RETURN_RESTORE)
        return_restore_wait_reg <= 1'b1;
      else if (return_restore_wait_reg && mc_tick)
        return_restore_wait_reg <= 1'b0;
      if (accept)
        in_service_reg <= 1'b1;
      else if (return_restore_wait_reg && mc_tick)
        in_service_reg <= 1'b0;
    end
  end

  // return stack of pc and psw high nibble
  logic [15:0] stack_mem [STACK_DEPTH];
  logic [SPW-1:0] sp_reg;
  always_ff @(posedge i_clk)
  begin
    if (accept)
      stack_mem[sp_reg] <= {i_psw_hi, i_pc};
  end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sp_reg <= '0;
      o_vector_call <= 1'b0;
      o_vector <= 12'h000;
      o_restore <= 1'b0;
      o_ret_pc <= 12'h000;
      o_ret_psw <= 4'h0; // bank 0
    end
    else
    begin
      o_vector_call <= accept;
      o_restore <= (i_op == OP_RETURN_RESTORE);
      if (accept)
      begin
        sp_reg <= sp_reg + 1'b1;
        o_vector <= pick_in ? VEC_HOST_IN : VEC_TIMER;
      end
      else if (i_op == OP_RETURN_RESTORE)
      begin
        sp_reg <= sp_reg - 1'b1;
        {o_ret_psw, o_ret_pc} <= stack_mem[sp_reg - 1'b1];
      end
    end
  end

  // port 2 latch and special pin functions
  logic drq_reg;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      flags_en_reg <= 1'b0;
      dma_en_reg <= 1'b0;
      drq_reg <= 1'b0;
      p2_latch_reg <= PORT_RST;
      o_port2 <= PORT_RST;
    end
    else
    begin
      if (i_op == OP_EN_FLAGS)
        flags_en_reg <= 1'b1;
      if (i_op == OP_EN_DMA)
        dma_en_reg <= 1'b1;
      if (i_op == OP_WRITE_P2)
        p2_latch_reg <= i_acc;
      // request on software one; cleared by enable or ack write
      if (i_op == OP_EN_DMA || (host_wr && dack_l_reg))
        drq_reg <= 1'b0;
      else if (i_op == OP_WRITE_P2 && i_acc[P2_DMA_REQ])
        drq_reg <= 1'b1;
      o_port2 <= p2_latch_reg;
      if (flags_en_reg)
      begin
        o_port2[P2_OUT_IRQ] <= p2_latch_reg[P2_OUT_IRQ] && out_full_reg;
        o_port2[P2_IN_IRQ] <= p2_latch_reg[P2_IN_IRQ] && !in_full_reg;
      end
      if (dma_en_reg)
      begin
        o_port2[P2_DMA_REQ] <= drq_reg;
        o_port2[P2_DMA_ACK] <= 1'b1;
      end
    end
  end

  // checks
  a_vector_order: assert property (@(posedge i_clk)
    disable iff (!i_nrst)
    accept && in_req_reg && in_irq_en_reg |=>
      o_vector_call && o_vector == VEC_HOST_IN)
    else $error("host_in request not serviced first");
  a_timer_vector: assert property (@(posedge i_clk)
    disable iff (!i_nrst)
    accept && !(in_req_reg && in_irq_en_reg) |=>
      o_vector == VEC_TIMER)
    else $error("timer vector wrong");
  a_req_kept: assert property (@(posedge i_clk)
    disable iff (!i_nrst)
    in_req_reg && !accept |=> in_req_reg)
    else $error("host_in request lost without entry");
  a_write_sets: assert property (@(posedge i_clk)
    disable iff (!i_nrst)
    host_wr |=> in_full_reg && in_req_reg &&
      cmd_flag_reg == $past(a0_l_reg))
    else $error("host write did not set flags");
  a_single_level: assert property (@(posedge i_clk)
    disable iff (!i_nrst)
    o_vector_call |-> !accept ##1 !o_vector_call)
    else $error("nested vector call");
  a_wrap_flag: assert property (@(posedge i_clk)
    disable iff (!i_nrst)
    wrap |=> tflag_reg && tmr_req_reg && count_q == 8'h00)
    else $error("wrap did not flag");
  a_event_count: assert property (@(posedge i_clk)
    disable iff (!i_nrst)
    cnt_mode_reg == CNT_EVENT && mc_tick && seen_high_reg && !pin_b_s &&
    i_op == OP_NONE |=> count_q == $past(count_q) + 8'h01)
    else $error("event not counted");
  a_stop_hold: assert property (@(posedge i_clk)
    disable iff (!i_nrst)
    cnt_mode_reg == CNT_STOP && i_op != OP_LOAD_COUNTER |=>
      $stable(count_q))
    else $error("counter moved while stopped");
  a_out_full: assert property (@(posedge i_clk)
    disable iff (!i_nrst)
    i_op == OP_WRITE_OUT |=> out_full_reg ##1 out_full_reg || host_rd_data
      || $past(host_rd_data))
    else $error("host_out_full not set");
  c_host_irq: cover property (@(posedge i_clk) disable iff (!i_nrst)
    host_wr ##[1:200] o_vector_call && o_vector == VEC_HOST_IN);
  c_timer_irq: cover property (@(posedge i_clk) disable iff (!i_nrst)
    wrap ##[1:200] o_vector_call && o_vector == VEC_TIMER);
  c_fifo_full: cover property (@(posedge i_clk) disable iff (!i_nrst)
    fifo_b_v_reg && o_in_valid);
endmodule

/* common/slave_port_pkg.sv */
// What this block does
// - begin_event_count routes event pin, keeps count
// - event pin sampled per cycle, high-then-low counts
// - interval timing counts machine cycles divided by 32
// - event pin stays testable; reset makes it test
// - halt_timer_counter stops counting, pin test-only
// - jump_if_test samples chosen pin, chosen polarity
// - host_in_full calls 3, overflow calls 7
// - host write raises request; only entry clears
// - finish instruction, push pc and psw, vector
// - return_restore restores pc, psw; re-enables later
// - service latency between four and seven cycles
// - single level; requests latched during service
// - host_in_full wins; timer request stays pending
// - host irq pins show out full and in not full, latch gated
// - dma pins: request on software one, ack selects
// - reset clears pc, sp, bank, irqs, flags; stops timer
// - two 8-bit buffers, host strobes, asynchronous
// - full flags set by writer, cleared by reader
// - write latches reg_select; flag ops; status nibble
// - reset clears whole host status register
// - status read on reg_select high, else buffer
// - counter wraps at maximum; reset never clears it
// - wrap sets overflow flag and timer request
package slave_port_pkg;
  // clock and machine cycle timing
  localparam int CLK_NS = 40;
  localparam int MACHINE_CYCLE_NS = 2500;
  localparam int MC_CLKS = MACHINE_CYCLE_NS / CLK_NS;
  localparam int PRESCALE = 32;
  localparam int TIMER_TICK_NS = 80000;
  // interrupt vectors
  localparam logic [11:0] VEC_HOST_IN = 12'h003;
  localparam logic [11:0] VEC_TIMER = 12'h007;
  // status bit positions
  localparam int ST_OUT_FULL = 0;
  localparam int ST_IN_FULL = 1;
  localparam int ST_USER_FLAG = 2;
  localparam int ST_CMD_FLAG = 3;
  localparam int ST_USER_LO = 4;
  // port 2 special bit positions
  localparam int P2_OUT_IRQ = 4;
  localparam int P2_IN_IRQ = 5;
  localparam int P2_DMA_REQ = 6;
  localparam int P2_DMA_ACK = 7;
  // reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'hff;
  // internal operations issued by the core
  typedef enum logic [4:0] {
    OP_NONE, OP_BEGIN_EVENT_COUNT, OP_START_TIMER, OP_STOP, OP_LOAD_COUNTER,
    OP_JUMP_TEST, OP_JUMP_TFLAG, OP_EN_IN_IRQ, OP_DIS_IN_IRQ,
    OP_EN_TMR_IRQ, OP_DIS_TMR_IRQ, OP_RETURN_RESTORE, OP_READ_IN,
    OP_WRITE_OUT, OP_CLR_USER_FLAG, OP_CPL_USER_FLAG, OP_CLR_CMD_FLAG,
    OP_CPL_CMD_FLAG,
    OP_LOAD_STATUS, OP_EN_FLAGS, OP_EN_DMA, OP_WRITE_P2
  } op_type;
  // counter source
  typedef enum logic [1:0] {CNT_STOP, CNT_EVENT, CNT_TIMER} cnt_mode_type;
endpackage

/* testbench/host_master.sv */
`timescale 1ns/100ps
// host side of the byte bus; strobes held 5 clocks, idle 9 clocks after writes, 5 after reads
module host_master (
  // clock
  input wire logic i_clk,
  // pins toward the block
  output logic o_cs_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_reg_select,
  output logic [7:0] o_data,
  output logic o_dack_n,
  // read return from the block
  input wire logic [7:0] i_data
);
  // all strobes idle at time zero
  initial
  begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_dack_n = 1'b1;
    o_reg_select = 1'b0;
    o_data = 8'h00;
  end
  // one byte write; dma mode selects with the ack pin
  task automatic write(input logic a0, input logic [7:0] d,
                       input logic dma);
    @(posedge i_clk);
    o_reg_select <= a0;
    o_data <= d;
    o_wr_n <= 1'b0;
    if (dma)
      o_dack_n <= 1'b0;
    else
      o_cs_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    // strobes drop before any service routine can end
    o_wr_n <= 1'b1;
    o_cs_n <= 1'b1;
    o_dack_n <= 1'b1;
    // data held past the synchroniser lag, then scrambled
    repeat (4) @(posedge i_clk);
    o_data <= ~d;
    repeat (5) @(posedge i_clk);
  endtask
  // one byte read; reg_select picks status or buffer
  task automatic read(input logic a0, output logic [7:0] d);
    @(posedge i_clk);
    o_reg_select <= a0;
    o_rd_n <= 1'b0;
    o_cs_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    d = i_data;
    o_rd_n <= 1'b1;
    o_cs_n <= 1'b1;
    repeat (5) @(posedge i_clk);
  endtask
endmodule

/* testbench/slave_port_tb.sv */
`timescale 1ns/100ps
module slave_port_tb;
  import slave_port_pkg::*;
  // clock, reset, bench counters
  logic clk;
  logic nrst;
  int n_mismatch = 0;
  int samples_checked = 0;
  // host pins
  logic cs_n, rd_n, wr_n, a0, dack_n, oe;
  logic [7:0] hin, hout, rd;
  // core side stimulus
  logic test_a = 1'b1;
  logic event_b = 1'b0;
  op_type cur_op = OP_NONE;
  logic [1:0] arg = 2'h0;
  logic [7:0] acc = 8'h00;
  logic in_ready = 1'b0;
  logic instr_end = 1'b0;
  logic [11:0] pc = 12'h000;
  logic [3:0] psw = 4'h0;
  // observed outputs
  logic [7:0] port2_out, counter, in_data, status;
  logic op_ready, branch, in_valid, vcall, restore;
  logic [11:0] vector, ret_pc;
  logic [3:0] ret_psw;
  // loop helpers
  op_type flag_ops [5] = '{OP_CPL_USER_FLAG, OP_CPL_CMD_FLAG,
                           OP_CLR_USER_FLAG, OP_CLR_CMD_FLAG,
                           OP_LOAD_STATUS};
  logic [7:0] flag_exp [5] = '{8'h04, 8'h0c, 8'h08, 8'h00, 8'ha0};
  int t;
  logic [7:0] v;
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // far end of the host bus
  host_master host (
    .i_clk(clk), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
    .o_reg_select(a0), .o_data(hin), .o_dack_n(dack_n), .i_data(hout)
  );
  slave_port DUT (
    .i_clk(clk), .i_nrst(nrst), .i_cs_n(cs_n), .i_rd_n(rd_n),
    .i_wr_n(wr_n), .i_reg_select(a0), .i_data(hin), .o_data(hout),
    .o_data_oe(oe), .i_test_pin_a(test_a), .i_event_pin_b(event_b),
    .i_port2({dack_n, 7'h7f}), .o_port2(port2_out), .i_op(cur_op),
    .i_op_arg(arg), .i_acc(acc), .o_op_ready(op_ready),
    .o_branch(branch), .o_counter(counter), .o_in_data(in_data),
    .o_in_valid(in_valid), .i_in_ready(in_ready),
    .i_instr_end(instr_end), .i_pc(pc), .i_psw_hi(psw),
    .o_vector_call(vcall), .o_vector(vector), .o_restore(restore),
    .o_ret_pc(ret_pc), .o_ret_psw(ret_psw), .o_status(status)
  );
  // compare and count
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one core operation, then time for flags and status to land
  task automatic op(input op_type o, input logic [7:0] a,
                    input logic [1:0] g = 2'h0);
    @(posedge clk);
    cur_op <= o;
    acc <= a;
    arg <= g;
    @(posedge clk);
    cur_op <= OP_NONE;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  // pop the buffer head toward the core
  task automatic pop(input logic [7:0] e);
    check("in_head", {7'h00, in_valid, in_data}, {7'h00, 1'b1, e});
    @(posedge clk);
    in_ready <= 1'b1;
    @(posedge clk);
    in_ready <= 1'b0;
    @(negedge clk);
  endtask
  // event pin level, held past three machine cycles
  task automatic pin_b(input logic lv);
    @(posedge clk);
    event_b <= lv;
    repeat (200) @(posedge clk);
  endtask
  // instruction boundary offered to the interrupt logic
  task automatic irq_try(input logic call, input logic [11:0] vec);
    @(posedge clk);
    instr_end <= 1'b1;
    pc <= 12'h123;
    psw <= 4'h5;
    @(posedge clk);
    instr_end <= 1'b0;
    @(negedge clk);
    check("vector_call", {15'h0, vcall}, {15'h0, call});
    if (call)
      check("vector", {4'h0, vector}, {4'h0, vec});
  endtask
  // return from service; wait out the re-enable tick
  task automatic ret();
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    cur_op <= OP_RETURN_RESTORE;
    @(posedge clk);
    cur_op <= OP_NONE;
    repeat (4)
    begin
      @(negedge clk);
      if (restore === 1'b1 && !seen)
      begin
        seen = 1'b1;
        check("ret_pc_psw", {ret_psw, ret_pc}, 16'h5123);
      end
    end
    check("restore_seen", {15'h0, seen}, 16'h0001);
    repeat (70) @(posedge clk);
  endtask
  // main sequence
  initial
  begin
    nrst = 1'b0;
    repeat (19) @(posedge clk);
    @(negedge clk);
    check("rst_status", {8'h00, status}, 16'h0000);
    check("rst_port2_oe", {port2_out, 7'h0, oe}, 16'hff00);
    @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // host writes, command flag follows reg_select
    host.write(1'b0, 8'ha5, 1'b0);
    check("st_data_wr", {8'h00, status}, 16'h0002);
    host.write(1'b1, 8'h5a, 1'b0);
    host.read(1'b1, rd);
    check("st_read", {8'h00, rd}, 16'h000a);
    // two-entry buffer: fill, refuse, drain in order
    op(OP_READ_IN, 8'h00);
    check("in_taken", {8'h00, status}, 16'h0008);
    host.write(1'b0, 8'hc3, 1'b0);
    op(OP_READ_IN, 8'h00);
    check("op_ready", {15'h0, op_ready}, 16'h0000);
    host.write(1'b0, 8'h99, 1'b0);
    op(OP_READ_IN, 8'h00);
    check("refused", {8'h00, status}, 16'h0002);
    pop(8'h5a);
    pop(8'hc3);
    op(OP_READ_IN, 8'h00);
    pop(8'h99);
    check("in_empty", {15'h0, in_valid}, 16'h0000);
    // output buffer: status read keeps the flag, data read clears
    op(OP_WRITE_OUT, 8'h3c);
    check("out_full", {8'h00, status}, 16'h0001);
    host.read(1'b1, rd);
    check("st_keep", {8'h00, rd}, 16'h0001);
    host.read(1'b0, rd);
    check("out_data", {8'h00, rd}, 16'h003c);
    check("out_clear", {8'h00, status}, 16'h0000);
    // software flags and user nibble
    for (int k = 0; k < 5; k++)
    begin
      op(flag_ops[k], 8'ha0);
      check("flags", {8'h00, status}, {8'h00, flag_exp[k]});
    end
    // both pins, both branch levels
    event_b <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      op(OP_JUMP_TEST, 8'h00, k[1:0]);
      check("branch", {15'h0, branch},
            {15'h0, (k[0] ? 1'b0 : 1'b1) == k[1]});
    end
    // event counting from a preset count, through the wrap
    op(OP_LOAD_COUNTER, 8'hff);
    op(OP_BEGIN_EVENT_COUNT, 8'h00);
    pin_b(1'b0);
    check("cnt_kept", {8'h00, counter}, 16'h00ff);
    pin_b(1'b1);
    pin_b(1'b0);
    check("cnt_wrap", {8'h00, counter}, 16'h0000);
    op(OP_JUMP_TEST, 8'h00, 2'h1);
    // pin b low, branch on low: taken even while counting
    check("pin_b_test", {15'h0, branch}, 16'h0001);
    op(OP_JUMP_TFLAG, 8'h00);
    check("tflag_set", {15'h0, branch}, 16'h0001);
    op(OP_JUMP_TFLAG, 8'h00);
    check("tflag_clr", {15'h0, branch}, 16'h0000);
    op(OP_STOP, 8'h00);
    pin_b(1'b1);
    pin_b(1'b0);
    check("cnt_stop", {8'h00, counter}, 16'h0000);
    // interval timing: edges between increments
    op(OP_START_TIMER, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      v = counter;
      t = 0;
      while (counter === v && t < 4200)
      begin
        @(posedge clk);
        t++;
      end
    end
    check("tick_clks", t[15:0], 16'(PRESCALE * MC_CLKS));
    op(OP_STOP, 8'h00);
    // pending host and timer requests, single level
    op(OP_DIS_IN_IRQ, 8'h00);
    op(OP_DIS_TMR_IRQ, 8'h00);
    irq_try(1'b0, VEC_HOST_IN);
    op(OP_EN_TMR_IRQ, 8'h00);
    op(OP_EN_IN_IRQ, 8'h00);
    irq_try(1'b1, VEC_HOST_IN);
    irq_try(1'b0, VEC_HOST_IN);
    ret();
    irq_try(1'b1, VEC_TIMER);
    ret();
    irq_try(1'b0, VEC_TIMER);
    // host flag pins, gated by the port latch
    op(OP_WRITE_P2, 8'hff);
    op(OP_EN_FLAGS, 8'h00);
    check("p2_flags0", {14'h0, port2_out[5:4]}, 16'h0002);
    op(OP_WRITE_OUT, 8'h11);
    check("p2_flags1", {14'h0, port2_out[5:4]}, 16'h0003);
    host.write(1'b0, 8'h42, 1'b0);
    check("p2_flags2", {14'h0, port2_out[5:4]}, 16'h0001);
    op(OP_WRITE_P2, 8'hcf);
    check("p2_gated", {14'h0, port2_out[5:4]}, 16'h0000);
    // dma request and a write selected by the ack
    op(OP_READ_IN, 8'h00);
    pop(8'h42);
    op(OP_EN_DMA, 8'h00);
    op(OP_WRITE_P2, 8'hff);
    check("dma_req", {15'h0, port2_out[6]}, 16'h0001);
    host.write(1'b0, 8'h77, 1'b1);
    check("dma_wr", {14'h0, status[1], port2_out[6]}, 16'h0002);
    wrap_up();
  end
  // hang guard, well past the expected run length
  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
endmodule
